// ---- core/sdct_pkg.sv ----
// Purpose: Constants and types shared by the command timing core
// Assumes: 100 MHz clock, period 10 ns
// Notes:   Times in ns are converted to cycles by rounding up
package sdct_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Round a least time up to whole cycles, never below one
   function automatic int sdct_ceil_cycles(input int t_ns);
      int c;
      c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int MODE_SET_SPACING_CYCLES = 2;
   localparam int MODE_SET_SPACING_TIME   = 15;
   localparam int ROW_TO_COLUMN_DELAY     = 15;
   localparam int PRECHARGE_PERIOD        = 15;
   localparam int ROW_OPEN_TIME           = 42;
   localparam int ROW_CYCLE_PERIOD        = 60;
   localparam int ACTIVATE_TO_ACTIVATE_GAP = 15;
   localparam int COLUMN_TO_COLUMN_GAP    = 1;
   localparam int WRITE_DATA_TO_PRECHARGE_GAP = 15;
   localparam int WRITE_DATA_TO_ACTIVATE_GAP  = 5;
   localparam int SELF_REFRESH_EXIT_CYCLES = 10;
   localparam int READ_MASK_DISABLE_LATENCY = 2;
   localparam int WRITE_MASK_LATENCY       = 0;
   localparam int SREX_START_EDGE          = 2;
   localparam int WR_RECOVERY_CYC = sdct_ceil_cycles(WRITE_DATA_TO_PRECHARGE_GAP);
   localparam int ROW_CYCLE_CYC   = sdct_ceil_cycles(ROW_CYCLE_PERIOD);
   localparam int CNT_W           = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
   // Device power state
   typedef enum logic [2:0] {
      SDCT_RUN  = 3'b001,
      SDCT_SELF = 3'b010,
      SDCT_EXIT = 3'b100
   } sdct_mode_t;
endpackage

// ---- core/sdct_delay.sv ----
// Purpose: Fixed-latency shift delay for a group of bits
// Assumes: Depth of at least one stage
// Notes:   Output comes from the last register stage
`timescale 1ns/10ps
module sdct_delay #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 2
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage_r [DEPTH];
   // One register per stage
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_st
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               stage_r[g] <= '0;
            end else begin
               stage_r[g] <= (g == 0) ? din : stage_r[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate
   assign dout = stage_r[DEPTH-1];
endmodule

// ---- core/sdct_core.sv ----
// Purpose: Device-side command timing of a four-bank synchronous DRAM
// Assumes: Controller keeps its own spacing limits; sys_rst stands in for power-up
// Notes:   Models self refresh entry and exit, data mask and write recovery
// Operation
// - Column commands may come every clock
// - Auto precharge starts after write recovery
// - Exit starts second edge after enable (here the fifth edge after cke_pin rises, behind the three sync stages)
// - Read mask disables outputs two later
// - Write mask acts with zero latency
`timescale 1ns/10ps
module sdct_core
   import sdct_pkg::*;
#(
   parameter int NBANK = 4,
   parameter int DW    = 16
) (
   input  wire logic                     clock,
   input  wire logic                     sys_rst,
   input  wire logic                     cke_pin,
   input  wire logic                     cs_n,
   input  wire logic                     ras_n,
   input  wire logic                     cas_n,
   input  wire logic                     we_n,
   input  wire logic [$clog2(NBANK)-1:0] bank_sel,
   input  wire logic                     auto_pre,
   input  wire logic                     dqm,
   input  wire logic [DW-1:0]            wr_data,
   input  wire logic [DW-1:0]            rd_data,
   output logic      [DW-1:0]            dq_out,
   output logic                          dq_oe,
   output logic                          store_en,
   output logic      [DW-1:0]            store_data,
   output logic      [NBANK-1:0]         bank_open,
   output logic      [NBANK-1:0]         bank_precharging,
   output logic                          self_refresh,
   output logic                          exit_busy
);
   // Whole state in one struct, except the read mask delay stages held in u_mask_dly
   typedef struct packed {
      logic [2:0]             cke_sync;
      logic                   cke_q;
      sdct_mode_t             mode;
      logic [CNT_W-1:0]       edge_cnt;
      logic [CNT_W-1:0]       exit_cnt;
      logic                   reading;
      logic [DW-1:0]          dq_out;
      logic                   dq_oe;
      logic                   store_en;
      logic [DW-1:0]          store_data;
      logic [NBANK-1:0]       bank_open;
      logic [NBANK-1:0]       ap_pend;
      logic [NBANK-1:0][CNT_W-1:0] wr_cnt;
      logic [NBANK-1:0]       pre_busy;
   } sdct_state_t;

   sdct_state_t st_r;
   sdct_state_t st_nxt;
   logic        mask_late;
   logic        cmd_act;
   logic        cmd_rd;
   logic        cmd_wr;
   logic        cmd_pre;
   logic        cmd_ref;
   logic        cke_level;

   // Read mask delayed to its disable latency
   sdct_delay #(
      .WIDTH (1),
      .DEPTH (READ_MASK_DISABLE_LATENCY)
   ) u_mask_dly (
      .clock   (clock),
      .sys_rst (sys_rst),
      .din     (dqm),
      .dout    (mask_late)
   );

   // Command decode, ignored outside normal running
   always_comb begin
      cmd_act = 1'b0;
      cmd_rd  = 1'b0;
      cmd_wr  = 1'b0;
      cmd_pre = 1'b0;
      cmd_ref = 1'b0;
      if (st_r.mode == SDCT_RUN && !cs_n) begin
         cmd_act = !ras_n && cas_n && we_n;
         cmd_rd  = ras_n && !cas_n && we_n;
         cmd_wr  = ras_n && !cas_n && !we_n;
         cmd_pre = !ras_n && cas_n && !we_n;
         cmd_ref = !ras_n && !cas_n && we_n;
      end
   end

   // Enable level counts once the second and third stages agree
   assign cke_level = (st_r.cke_sync[1] == st_r.cke_sync[2]) ? st_r.cke_sync[2] : st_r.cke_q;

   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.cke_sync = {st_r.cke_sync[1:0], cke_pin};
      st_nxt.cke_q = cke_level;
      st_nxt.store_en = 1'b0;
      // Zero-latency write mask drops same-cycle data
      if (st_r.mode == SDCT_RUN && cmd_wr && !dqm) begin
         st_nxt.store_en   = 1'b1;
         st_nxt.store_data = wr_data;
      end
      // Read path: output disabled two cycles after mask
      if (cmd_rd) begin
         st_nxt.reading = 1'b1;
      end else if (cmd_wr || cmd_pre) begin
         st_nxt.reading = 1'b0;
      end
      // Drive from the cycle after the read, so the read answers next cycle
      st_nxt.dq_oe  = st_nxt.reading && !mask_late;
      st_nxt.dq_out = rd_data;
      // Per-bank row state and write recovery
      for (int b = 0; b < NBANK; b++) begin
         st_nxt.pre_busy[b] = 1'b0;
         if (cmd_act && bank_sel == b[$clog2(NBANK)-1:0]) begin
            st_nxt.bank_open[b] = 1'b1;
            st_nxt.ap_pend[b]   = 1'b0;
         end
         if (cmd_pre && bank_sel == b[$clog2(NBANK)-1:0]) begin
            st_nxt.bank_open[b]  = 1'b0;
            st_nxt.pre_busy[b]   = 1'b1;
         end
         if (cmd_wr && bank_sel == b[$clog2(NBANK)-1:0]) begin
            st_nxt.ap_pend[b] = auto_pre;
            st_nxt.wr_cnt[b]  = CNT_W'(WR_RECOVERY_CYC);
         end else if (st_r.ap_pend[b]) begin
            // Internal precharge once recovery has run out
            if (st_r.wr_cnt[b] == CNT_ONE) begin
               st_nxt.ap_pend[b]   = 1'b0;
               st_nxt.bank_open[b] = 1'b0;
               st_nxt.pre_busy[b]  = 1'b1;
            end
            if (st_r.wr_cnt[b] != CNT_ZERO) begin
               st_nxt.wr_cnt[b] = st_r.wr_cnt[b] - CNT_ONE;
            end
         end
      end
      // Power state machine
      case (st_r.mode)
         SDCT_RUN: begin
            if (cmd_ref && !cke_level) begin
               st_nxt.mode    = SDCT_SELF;
               st_nxt.reading = 1'b0;
            end
         end
         SDCT_SELF: begin
            // Exit starts on second edge after enable rises
            if (cke_level) begin
               st_nxt.edge_cnt = st_r.edge_cnt + CNT_ONE;
               if (st_r.edge_cnt == CNT_W'(SREX_START_EDGE - 1)) begin
                  st_nxt.mode     = SDCT_EXIT;
                  st_nxt.edge_cnt = CNT_ZERO;
                  st_nxt.exit_cnt = CNT_W'(ROW_CYCLE_CYC);
               end
            end else begin
               st_nxt.edge_cnt = CNT_ZERO;
            end
         end
         SDCT_EXIT: begin
            // Busy for one row cycle after exit registers
            if (st_r.exit_cnt == CNT_ONE) begin
               st_nxt.mode = SDCT_RUN;
            end
            st_nxt.exit_cnt = st_r.exit_cnt - CNT_ONE;
         end
         default: begin
            st_nxt.mode = SDCT_RUN;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_r      <= '0;
         st_r.mode <= SDCT_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state flip-flops
   assign dq_out           = st_r.dq_out;
   assign dq_oe            = st_r.dq_oe;
   assign store_en         = st_r.store_en;
   assign store_data       = st_r.store_data;
   assign bank_open        = st_r.bank_open;
   assign bank_precharging = st_r.pre_busy;
   assign self_refresh     = st_r.mode[1];  // One-hot bit of the self refresh state
   assign exit_busy        = st_r.mode[2];  // One-hot bit of the exit state
endmodule

// ---- test/sdct_properties.sv ----
// Purpose: Port assertions for the command timing core
// Assumes: One clock, reset synchronous and active high
// Notes:   Bound to every sdct_core instance
`timescale 1ns/10ps
module sdct_properties
   import sdct_pkg::*;
#(
   parameter int NBANK = 4,
   parameter int DW    = 16
) (
   input wire logic                     clock,
   input wire logic                     sys_rst,
   input wire logic                     cke_pin,
   input wire logic                     cs_n,
   input wire logic                     ras_n,
   input wire logic                     cas_n,
   input wire logic                     we_n,
   input wire logic [$clog2(NBANK)-1:0] bank_sel,
   input wire logic                     auto_pre,
   input wire logic                     dqm,
   input wire logic [DW-1:0]            wr_data,
   input wire logic                     dq_oe,
   input wire logic                     store_en,
   input wire logic [DW-1:0]            store_data,
   input wire logic [NBANK-1:0]         bank_precharging,
   input wire logic                     self_refresh,
   input wire logic                     exit_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Column command accepted in run mode
   wire logic col_go = !cs_n && !self_refresh && !exit_busy && ras_n && !cas_n;
   // Auto-precharge write, and a masked read with no new command
   sequence s_wr_ap;
      col_go && !we_n && auto_pre;
   endsequence
   sequence s_mask_idle;
      dq_oe && dqm && cs_n ##1 cs_n [*2];
   endsequence
   a_write_stored: assert property (
      col_go && !we_n && !dqm |=> store_en && store_data == $past(wr_data))
      else $error("write data not stored");
   a_write_masked: assert property (
      col_go && !we_n && dqm |=> !store_en) else $error("masked write stored");
   a_read_drive: assert property (
      col_go && we_n |=> dq_oe) else $error("read not driven");
   a_read_mask: assert property (
      s_mask_idle |=> !dq_oe) else $error("mask did not stop outputs");
   a_ap_recovery: assert property (
      s_wr_ap |=> !bank_precharging[$past(bank_sel)] ##1 !bank_precharging[$past(bank_sel, 2)]
      ##1 bank_precharging[$past(bank_sel, 3)]) else $error("auto precharge mistimed");
   a_exit_start: assert property (
      $rose(cke_pin) && self_refresh |=> !exit_busy ##[1:11] exit_busy)
      else $error("self refresh exit mistimed");
   a_exit_length: assert property (
      $rose(exit_busy) |-> exit_busy [*6] ##1 !exit_busy) else $error("exit length wrong");
   a_self_ignore: assert property (
      self_refresh && !cs_n |=> !store_en) else $error("command taken in self refresh");
endmodule
bind sdct_core sdct_properties #(.NBANK(NBANK), .DW(DW)) u_props (.clock, .sys_rst,
   .cke_pin, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel, .auto_pre, .dqm, .wr_data, .dq_oe,
   .store_en, .store_data, .bank_precharging, .self_refresh, .exit_busy);

// ---- test/sdct_ctl_model.sv ----
// Purpose: Controller model that issues spaced commands
// Assumes: Pins change at the falling clock edge
// Notes:   Spacing is kept by idle cycles after each command
`timescale 1ns/10ps
module sdct_ctl_model (
   input  wire logic        clock,
   output logic             cke_pin,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [1:0]       bank_sel,
   output logic             auto_pre,
   output logic             dqm,
   output logic [15:0]      wr_data,
   output logic [15:0]      rd_data
);
   // Least spacings in cycles, fractions rounded up
   localparam int T_RCD = (15 + 9) / 10;
   localparam int T_RP  = (15 + 9) / 10;
   localparam int T_DAL = 5;
   localparam int T_MRD = 2;
   localparam int T_RSC = (15 + 9) / 10;
   localparam int T_RAS = (42 + 9) / 10;
   localparam int T_RC  = (60 + 9) / 10;
   localparam int T_RRD = (12 + 9) / 10;
   localparam int T_REF_CNT = 8192;
   // Idle pins at power-up
   initial begin
      {cke_pin, cs_n, ras_n, cas_n, we_n, auto_pre, dqm} = 7'h7C;
      bank_sel = 2'h0;
      wr_data = 16'h0;
      rd_data = 16'h1234;
   end
   // One command, held until the next falling edge
   task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic ap, m,
                      input logic [15:0] d);
      {cs_n, ras_n, cas_n, we_n} = {1'b0, rcw};
      bank_sel = b;
      auto_pre = ap;
      dqm = m;
      wr_data = d;
      @(posedge clock);
      @(negedge clock);
   endtask
   // Idle cycles; released data keeps changing so nothing stale is seen
   task automatic nop(input int n, input logic m);
      repeat (n) begin
         {cs_n, ras_n, cas_n, we_n} = 4'hF;
         auto_pre = 1'b0;
         dqm = m;
         wr_data = ~wr_data;
         rd_data = rd_data + 16'h1111;
         @(posedge clock);
         @(negedge clock);
      end
   endtask
endmodule

// ---- test/sdct_core_tb.sv ----
// Purpose: Self-checking bench for the command timing core
// Assumes: Controller model drives all command pins
// Notes:   Each scenario judges its own results
`timescale 1ns/10ps
module sdct_core_tb
   import sdct_pkg::*;
;
   localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, PRE = 3'h2, REF = 3'h1;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cke_pin, cs_n, ras_n, cas_n, we_n, auto_pre, dqm;
   logic        dq_oe, store_en, self_refresh, exit_busy;
   logic [1:0]  bank_sel;
   logic [15:0] wr_data, rd_data, dq_out, store_data;
   logic [3:0]  bank_open, bank_precharging;
   int          n_errors = 0;
   int          checks = 0;
   int          n;
   always #5 clock = ~clock;
   sdct_ctl_model u_ctl (.clock, .cke_pin, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel,
      .auto_pre, .dqm, .wr_data, .rd_data);
   sdct_core u_dut (.clock, .sys_rst, .cke_pin, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel,
      .auto_pre, .dqm, .wr_data, .rd_data, .dq_out, .dq_oe, .store_en, .store_data,
      .bank_open, .bank_precharging, .self_refresh, .exit_busy);
   // Compare one value and count the result
   task automatic chk(input string what, input logic [15:0] exp, got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Write to bank 1 and judge what is stored
   task automatic wr_chk(input logic m, input logic [15:0] d);
      u_ctl.cmd(WR, 2'h1, 1'b0, m, d);
      chk("store_en", {15'h0, ~m}, {15'h0, store_en});
      if (!m) chk("store_data", d, store_data);
   endtask
   // Back-to-back writes with the middle one masked
   task automatic t_write();
      u_ctl.cmd(ACT, 2'h1, 1'b0, 1'b0, 16'h0);
      u_ctl.nop(u_ctl.T_RCD - 1, 1'b0);
      wr_chk(1'b0, 16'hA5C3);
      wr_chk(1'b1, 16'h5A3C);
      wr_chk(1'b0, 16'h0FF0);
      u_ctl.nop(1, 1'b0);
      $display("t_write done");
   endtask
   // Read, then mask the outputs off
   task automatic t_read();
      u_ctl.cmd(RD, 2'h1, 1'b0, 1'b0, 16'h0);
      chk("dq_oe", 16'h1, {15'h0, dq_oe});
      chk("dq_out", u_ctl.rd_data, dq_out);
      u_ctl.nop(2, 1'b1);
      chk("dq_oe", 16'h1, {15'h0, dq_oe});
      u_ctl.nop(1, 1'b1);
      chk("dq_oe", 16'h0, {15'h0, dq_oe});
      u_ctl.nop(1, 1'b0);
      $display("t_read done");
   endtask
   // Auto-precharge write waits out write recovery
   task automatic t_autopre();
      u_ctl.cmd(ACT, 2'h2, 1'b0, 1'b0, 16'h0);
      u_ctl.nop(u_ctl.T_RCD - 1, 1'b0);
      u_ctl.cmd(WR, 2'h2, 1'b1, 1'b0, 16'h1234);
      u_ctl.nop(1, 1'b0);
      chk("precharging", 16'h0, {12'h0, bank_precharging});
      u_ctl.nop(1, 1'b0);
      chk("precharging", 16'h4, {12'h0, bank_precharging});
      chk("bank_open", 16'h2, {12'h0, bank_open});
      u_ctl.nop(u_ctl.T_DAL, 1'b0);
      u_ctl.nop(u_ctl.T_RC + u_ctl.T_RRD, 1'b0);
      $display("t_autopre done");
   endtask
   // Self refresh entry, ignored command, exit length
   task automatic t_self();
      u_ctl.nop(u_ctl.T_RAS, 1'b0);
      u_ctl.cmd(PRE, 2'h1, 1'b0, 1'b0, 16'h0);
      u_ctl.nop(u_ctl.T_RP, 1'b0);
      u_ctl.cke_pin = 1'b0;
      u_ctl.nop(4, 1'b0);
      u_ctl.cmd(REF, 2'h0, 1'b0, 1'b0, 16'h0);
      chk("self_refresh", 16'h1, {15'h0, self_refresh});
      u_ctl.cmd(WR, 2'h1, 1'b0, 1'b0, 16'hBEEF);
      chk("store_en", 16'h0, {15'h0, store_en});
      u_ctl.nop(2, 1'b0);
      u_ctl.cke_pin = 1'b1;
      n = 0;
      for (int i = 0; i < 30; i++) begin
         u_ctl.nop(1, 1'b0);
         if (exit_busy === 1'b1) n++;
      end
      chk("exit_cycles", 16'(ROW_CYCLE_CYC), 16'(n));
      chk("self_refresh", 16'h0, {15'h0, self_refresh});
      $display("t_self done");
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      u_ctl.nop(1, 1'b0);
      t_write();
      t_read();
      t_autopre();
      t_self();
      stop_test();
   end
   // Watchdog well beyond the expected run
   initial begin
      #(2000 * 10);
      n_errors++;
      stop_test();
   end
endmodule
